//--- common/quad_counter_pkg.sv
// Purpose: shared constants and types for the quadrature counter bus port
// Assumes: one 200 MHz clock, all pin inputs asynchronous to it
// Notes:   the position counter exists in a 12-bit and a 16-bit variant
package quad_counter_pkg;

  localparam int          CLK_PERIOD_NS   = 5;
  localparam int          POS_WIDTH_SHORT = 12;
  localparam int          POS_WIDTH_FULL  = 16;
  localparam int          BYTE_WIDTH      = 8;
  localparam int          FILTER_DEPTH    = 3;

  localparam logic [15:0] POS_RESET       = 16'h0000;
  localparam logic [15:0] POS_ONE         = 16'h0001;
  localparam logic [15:0] POS_MAX_SHORT   = 16'h0FFF;
  localparam logic [15:0] POS_MAX_FULL    = 16'hFFFF;

  localparam logic [7:0]  HIGH_MASK_SHORT = 8'h0F;
  localparam logic [7:0]  HIGH_MASK_FULL  = 8'hFF;
  localparam logic [7:0]  BYTE_RESET      = 8'h00;

  // pin vector order {byte_sel, oe_n, phase_b, phase_a}; oe_n idles high
  localparam int          PIN_A           = 0;
  localparam int          PIN_B           = 1;
  localparam int          PIN_OE_N        = 2;
  localparam int          PIN_SEL         = 3;
  localparam logic [3:0]  PIN_SYNC_RESET  = 4'h4;

  localparam logic        SEL_HIGH_BYTE   = 1'b0;

  typedef enum logic [1:0] {
    INH_IDLE,
    INH_HIGH_READ,
    INH_LOW_READ
  } inhibit_state_t;

endpackage

//--- logic/phase_filter.sv
// Purpose: three-sample stability filter for one synchronised phase input
// Assumes: sample_i is already synchronised to clk_i
// Notes:   pulses shorter than the filter depth never reach filt_o
`timescale 1ns/10ps
`default_nettype none
module phase_filter
  import quad_counter_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic sample_i,
  output var  logic filt_o
);

  logic [FILTER_DEPTH-1:0] hist_reg;
  logic                    filt_reg;
  wire                     all_high;
  wire                     all_low;

  assign all_high = &hist_reg;
  assign all_low  = ~|hist_reg;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hist_reg <= '0;
      filt_reg <= 1'b0;
    end else begin
      hist_reg <= {hist_reg[FILTER_DEPTH-2:0], sample_i};
      if (all_high) begin
        filt_reg <= 1'b1;
      end else if (all_low) begin
        filt_reg <= 1'b0;
      end
    end
  end

  assign filt_o = filt_reg;

  chk_filter_stable_level: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    $changed(filt_reg) |-> ($past(hist_reg) == {FILTER_DEPTH{filt_reg}}))
    else $error("filtered phase changed without three equal samples");

endmodule // phase_filter
`default_nettype wire

//--- logic/quadrature_counter_bus_port.sv
// Purpose: quadrature decoder, up/down position counter, position latch
//          and byte-wide read port with read-inhibit logic
// Assumes: encoder phases, oe_n and byte select are asynchronous pins
// Notes:   pin inputs pass two flops, so the port answers a few cycles late
//
// Behaviour
// - reset clears counter and latch asynchronously
// - reset also returns inhibit logic to idle
// - data port driven only while enable low
// - inhibit samples enable and select on falling edges
// - select 0 gives high byte, 1 low
// - position read high byte first, then low
// - 12-bit variant reads upper nibble as zero
// - one step pulse per valid transition
// - direction high up, settled before pulses
// - one cascade pulse per overflow or underflow
// - phase changes pass after three stable samples
// - A leading counts up, B leading down
// - count on every edge of both phases
`timescale 1ns/10ps
`default_nettype none
module quadrature_counter_bus_port
  import quad_counter_pkg::*;
#(
  parameter int POS_WIDTH = POS_WIDTH_FULL
)(
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       phase_a_in_i,
  input  wire logic       phase_b_in_i,
  input  wire logic       oe_n_i,
  input  wire logic       byte_sel_i,
  output var  logic [7:0] data_port_bits_o,
  output var  logic       data_port_bits_oe_o,
  output var  logic       decoder_step_pulse_o,
  output var  logic       count_up_o,
  output var  logic       carry_borrow_pulse_o
);

  localparam logic [15:0] POS_MAX   = (POS_WIDTH == POS_WIDTH_SHORT) ?
                                      POS_MAX_SHORT : POS_MAX_FULL;
  localparam logic [7:0]  HIGH_MASK = (POS_WIDTH == POS_WIDTH_SHORT) ?
                                      HIGH_MASK_SHORT : HIGH_MASK_FULL;

  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  logic [3:0]     pin_s1_reg;
  logic [3:0]     pin_s2_reg;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1_reg <= PIN_SYNC_RESET;
      pin_s2_reg <= PIN_SYNC_RESET;
    end else begin
      pin_s1_reg <= {byte_sel_i, oe_n_i, phase_b_in_i, phase_a_in_i};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  wire            oe_n_s;
  wire            sel_s;

  assign oe_n_s = pin_s2_reg[PIN_OE_N];
  assign sel_s  = pin_s2_reg[PIN_SEL];

  // ---------------------------------------------------------------------
  // noise filters, one per phase; the encoder must deliver two phases in
  // quadrature, anything else yields erroneous counts
  // ---------------------------------------------------------------------
  logic [1:0]     phase_filt;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_phase
      phase_filter u_filter (
        .clk_i    (clk_i),
        .nrst_i   (nrst_i),
        .sample_i (pin_s2_reg[gi]),
        .filt_o   (phase_filt[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------------
  // quadrature decoder
  // ---------------------------------------------------------------------
  logic [1:0]     phase_prev_reg;

  wire            a_now;
  wire            b_now;
  wire            a_prev;
  wire            b_prev;
  wire            step_valid;
  wire            dir_up_now;

  assign a_now      = phase_filt[PIN_A];
  assign b_now      = phase_filt[PIN_B];
  assign a_prev     = phase_prev_reg[PIN_A];
  assign b_prev     = phase_prev_reg[PIN_B];
  // exactly one phase moved; a double change is illegal and not counted
  assign step_valid = (a_now ^ a_prev) ^ (b_now ^ b_prev);
  // up when A leads: 00-10-11-01-00
  assign dir_up_now = b_prev ^ a_now;

  // ---------------------------------------------------------------------
  // position counter
  // ---------------------------------------------------------------------
  logic [15:0]    count_reg;
  wire  [15:0]    count_next;
  wire            wrap_up;
  wire            wrap_down;
  wire            wrap_now;

  assign wrap_up    = step_valid &  dir_up_now & (count_reg == POS_MAX);
  assign wrap_down  = step_valid & ~dir_up_now & (count_reg == POS_RESET);
  assign wrap_now   = wrap_up | wrap_down;
  assign count_next = wrap_up    ? POS_RESET :
                      wrap_down  ? POS_MAX :
                      dir_up_now ? count_reg + POS_ONE :
                                   count_reg - POS_ONE;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_reg      <= POS_RESET;
      phase_prev_reg <= 2'h0;
    end else begin
      phase_prev_reg <= phase_filt;
      if (step_valid) begin
        count_reg <= count_next;
      end
    end
  end

  // ---------------------------------------------------------------------
  // direction and pulse outputs; pulses trail the direction by one cycle
  // so direction is stable at every pulse rising edge
  // ---------------------------------------------------------------------
  logic           dir_up_reg;
  logic           step_pend_reg;
  logic           wrap_pend_reg;
  logic           step_pulse_reg;
  logic           cascade_pulse_reg;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dir_up_reg        <= 1'b1;
      step_pend_reg     <= 1'b0;
      wrap_pend_reg     <= 1'b0;
      step_pulse_reg    <= 1'b0;
      cascade_pulse_reg <= 1'b0;
    end else begin
      if (step_valid) begin
        dir_up_reg <= dir_up_now;
      end
      step_pend_reg     <= step_valid;
      wrap_pend_reg     <= wrap_now;
      step_pulse_reg    <= step_pend_reg;
      cascade_pulse_reg <= wrap_pend_reg;
    end
  end

  assign count_up_o           = dir_up_reg;
  assign decoder_step_pulse_o = step_pulse_reg;
  assign carry_borrow_pulse_o = cascade_pulse_reg;

  // ---------------------------------------------------------------------
  // read-inhibit logic on the falling edge
  // ---------------------------------------------------------------------
  inhibit_state_t inh_reg;
  inhibit_state_t inh_next;
  wire            read_high;
  wire            read_low;

  assign read_high = ~oe_n_s & (sel_s == SEL_HIGH_BYTE);
  assign read_low  = ~oe_n_s & (sel_s != SEL_HIGH_BYTE);

  always_comb begin
    inh_next = inh_reg;
    case (inh_reg)
      INH_IDLE: begin
        if (read_high) begin
          inh_next = INH_HIGH_READ;
        end
      end
      INH_HIGH_READ: begin
        if (read_low) begin
          inh_next = INH_LOW_READ;
        end
      end
      INH_LOW_READ: begin
        if (oe_n_s) begin
          inh_next = INH_IDLE;
        end
      end
      default: begin
        inh_next = INH_IDLE;
      end
    endcase
  end

  always_ff @(negedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      inh_reg <= INH_IDLE;
    end else begin
      inh_reg <= inh_next;
    end
  end

  // ---------------------------------------------------------------------
  // position latch and byte port
  // ---------------------------------------------------------------------
  logic [15:0]    pos_latch_reg;
  logic [7:0]     data_reg;
  logic           data_oe_reg;
  wire            latch_load;
  wire  [7:0]     high_byte;
  wire  [7:0]     byte_mux;

  assign latch_load = (inh_reg == INH_IDLE);
  assign high_byte  = pos_latch_reg[15:8] & HIGH_MASK;
  assign byte_mux   = (sel_s == SEL_HIGH_BYTE) ? high_byte :
                                                 pos_latch_reg[7:0];

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pos_latch_reg <= POS_RESET;
      data_reg      <= BYTE_RESET;
      data_oe_reg   <= 1'b0;
    end else begin
      if (latch_load) begin
        pos_latch_reg <= count_reg;
      end
      data_reg    <= byte_mux;
      data_oe_reg <= ~oe_n_s;
    end
  end

  assign data_port_bits_o    = data_reg;
  assign data_port_bits_oe_o = data_oe_reg;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence up_step_s;
    step_valid && dir_up_now;
  endsequence

  sequence wrap_s;
    step_valid && (dir_up_now ? (count_reg == POS_MAX) : (count_reg == POS_RESET));
  endsequence

  sequence pulse_after_s;
    ##1 step_pend_reg ##1 decoder_step_pulse_o;
  endsequence

  // judged one tick on, so the first edge of the run, before any reset
  // event has reached the flops, is not held against them
  chk_reset_clears_all: assert property (
    @(posedge clk_i) disable iff (1'b0)
    !nrst_i |=> (count_reg == POS_RESET && pos_latch_reg == POS_RESET
                 && inh_reg == INH_IDLE))
    else $error("reset left counter, latch or inhibit state set");

  chk_port_drive_enable: assert property (
    data_port_bits_oe_o == !$past(oe_n_s))
    else $error("data port enable does not follow synchronised oe_n");

  chk_byte_high_first: assert property (
    (sel_s == SEL_HIGH_BYTE) |=> data_port_bits_o == ($past(pos_latch_reg[15:8]) & HIGH_MASK))
    else $error("high byte not presented for select 0");

  chk_byte_low_second: assert property (
    (sel_s != SEL_HIGH_BYTE) |=> data_port_bits_o == $past(pos_latch_reg[7:0]))
    else $error("low byte not presented for select 1");

  chk_short_nibble_zero: assert property (
    (POS_WIDTH == POS_WIDTH_SHORT) && data_port_bits_oe_o && $past(sel_s) == SEL_HIGH_BYTE
    |-> data_port_bits_o[7:4] == 4'h0)
    else $error("upper nibble of short high byte not zero");

  chk_step_pulse_once: assert property (
    step_valid |-> pulse_after_s ##1 (!decoder_step_pulse_o || $past(step_valid, 2)))
    else $error("step pulse missing or stretched");

  chk_dir_before_pulse: assert property (
    $rose(decoder_step_pulse_o) || $rose(carry_borrow_pulse_o)
    |-> $stable(count_up_o))
    else $error("direction moved at a pulse rising edge");

  chk_cascade_wrap: assert property (
    wrap_s |=> (count_reg == (dir_up_reg ? POS_RESET : POS_MAX)) ##1 carry_borrow_pulse_o)
    else $error("wrap without cascade pulse or wrong wrap value");

  chk_no_spurious_cascade: assert property (
    carry_borrow_pulse_o |-> $past(wrap_now, 2))
    else $error("cascade pulse without counter wrap");

  chk_count_up_step: assert property (
    up_step_s and (count_reg != POS_MAX) |=> count_reg == $past(count_reg) + POS_ONE)
    else $error("up step did not increment the counter");

  chk_count_down_step: assert property (
    step_valid && !dir_up_now && (count_reg != POS_RESET)
    |=> count_reg == $past(count_reg) - POS_ONE)
    else $error("down step did not decrement the counter");

  chk_count_hold_idle: assert property (
    !step_valid |=> $stable(count_reg))
    else $error("counter moved without a decoder step");

  chk_latch_frozen_read: assert property (
    (inh_reg != INH_IDLE) |=> $stable(pos_latch_reg))
    else $error("latch loaded while a read was in progress");

  // the inhibit state moves on falling edges, so it is judged there too
  chk_inhibit_sampling: assert property (
    @(negedge clk_i) (inh_reg == INH_IDLE) && read_high |=> inh_reg == INH_HIGH_READ)
    else $error("inhibit did not catch a high byte read");

endmodule // quadrature_counter_bus_port
`default_nettype wire

//--- verif/quad_partner_model.sv
// Purpose: encoder and microprocessor read side for the counter bench
// Assumes: every output changes on a falling clock edge only
// Notes:   index order 00,10,11,01 on {a,b} means channel A leads when stepping up
`timescale 1ns/10ps
`default_nettype none
module quad_partner_model (
  input  wire logic clk_i,
  output var  logic phase_a_o,
  output var  logic phase_b_o,
  output var  logic oe_n_o,
  output var  logic byte_sel_o
);
  logic [1:0] idx_reg;

  initial begin
    idx_reg    = 2'h0;
    phase_a_o  = 1'b0;
    phase_b_o  = 1'b0;
    oe_n_o     = 1'b1;
    byte_sel_o = 1'b1;
  end

  // only one channel moves per step, which keeps the phases a quarter cycle apart
  task automatic step(input bit up, input int gap);
    @(negedge clk_i);
    idx_reg = up ? idx_reg + 2'h1 : idx_reg - 2'h1;
    phase_a_o = ^idx_reg;
    phase_b_o = idx_reg[1];
    repeat (gap) @(negedge clk_i);
  endtask

  // short spike on channel A, meant to be swallowed by the input filter
  task automatic glitch(input int len);
    @(negedge clk_i);
    phase_a_o = ~phase_a_o;
    repeat (len) @(negedge clk_i);
    phase_a_o = ~phase_a_o;
    repeat (10) @(negedge clk_i);
  endtask

  // pins held four cycles, one more than the port latency
  task automatic bus(input logic oe_n, input logic sel);
    @(negedge clk_i);
    oe_n_o     = oe_n;
    byte_sel_o = sel;
    repeat (4) @(negedge clk_i);
  endtask
endmodule // quad_partner_model
`default_nettype wire

//--- verif/tb_top.sv
// Purpose: self-checking bench for the quadrature counter bus port
// Assumes: 200 MHz clock, inputs change on falling edges
// Notes:   a 16-bit and a 12-bit instance share every input
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import quad_counter_pkg::*;
  logic        clk, nrst, pa, pb, oe_n, sel;
  logic [7:0]  d16, d12;
  logic        oe16, oe12, step16, up16, casc16, casc12;
  logic [15:0] pos_exp;
  int          mismatches, checked, steps_seen, casc16_seen, casc12_seen;
  int          steps_exp, casc16_exp, casc12_exp;

  quad_partner_model host_u (.clk_i(clk), .phase_a_o(pa), .phase_b_o(pb), .oe_n_o(oe_n),
    .byte_sel_o(sel));
  quadrature_counter_bus_port dut_u (
    .clk_i(clk), .nrst_i(nrst), .phase_a_in_i(pa), .phase_b_in_i(pb), .oe_n_i(oe_n),
    .byte_sel_i(sel), .data_port_bits_o(d16), .data_port_bits_oe_o(oe16),
    .decoder_step_pulse_o(step16), .count_up_o(up16), .carry_borrow_pulse_o(casc16));
  quadrature_counter_bus_port #(.POS_WIDTH(POS_WIDTH_SHORT)) dut_short_u (
    .clk_i(clk), .nrst_i(nrst), .phase_a_in_i(pa), .phase_b_in_i(pb), .oe_n_i(oe_n),
    .byte_sel_i(sel), .data_port_bits_o(d12), .data_port_bits_oe_o(oe12),
    .decoder_step_pulse_o(), .count_up_o(), .carry_borrow_pulse_o(casc12));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // pulses launch on rising edges, so they are counted on falling ones
  always @(negedge clk) begin
    if (step16 === 1'b1) steps_seen++;
    if (casc16 === 1'b1) casc16_seen++;
    if (casc12 === 1'b1) casc12_seen++;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // expected high byte as the port presents it for either counter width
  function automatic logic [7:0] high_exp(input logic [15:0] pos, input bit short);
    high_exp = short ? {4'h0, pos[11:8]} : pos[15:8];
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // the bench keeps its own position; wraps are judged for both widths
  task automatic do_step(input bit up, input int gap);
    host_u.step(up, gap);
    steps_exp++;
    if (up ? pos_exp[11:0] == 12'hfff : pos_exp[11:0] == 12'h000) casc12_exp++;
    if (up ? pos_exp == 16'hffff : pos_exp == 16'h0000) casc16_exp++;
    pos_exp = up ? pos_exp + 16'h0001 : pos_exp - 16'h0001;
    if (gap >= 9) chk({15'h0000, up16}, {15'h0000, up});
  endtask

  task automatic rd_high(input logic [15:0] exp);
    host_u.bus(1'b0, SEL_HIGH_BYTE);
    chk({14'h0000, oe16, oe12}, 16'h0003);
    chk({8'h00, d16}, {8'h00, high_exp(exp, 1'b0)});
    chk({8'h00, d12}, {8'h00, high_exp(exp, 1'b1)});
  endtask

  task automatic rd_low(input logic [15:0] exp);
    host_u.bus(1'b0, 1'b1);
    chk({d16, d12}, {exp[7:0], exp[7:0]});
  endtask

  task automatic rd_all(input logic [15:0] exp);
    rd_high(exp);
    rd_low(exp);
    host_u.bus(1'b1, 1'b1);
    chk({14'h0000, oe16, oe12}, 16'h0000);
  endtask

  initial begin
    #(CLK_PERIOD_NS * 40000);
    mismatches++;
    end_of_test();
  end

  initial begin
    nrst = 1'b0;
    mismatches = 0;
    checked = 0;
    steps_seen = 0;
    casc16_seen = 0;
    casc12_seen = 0;
    steps_exp = 0;
    casc16_exp = 0;
    casc12_exp = 0;
    pos_exp = 16'h0000;
    void'($urandom(32'h96a1));
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    rd_all(16'h0000);
    for (int i = 0; i < 6; i++) do_step(1'b1, 10);
    rd_all(pos_exp);
    host_u.glitch(2);
    rd_all(pos_exp);
    while (pos_exp != 16'h0000) do_step(1'b0, 10);
    do_step(1'b0, 10);
    rd_all(pos_exp);
    do_step(1'b1, 10);
    rd_all(pos_exp);
    // a count arriving between the two byte reads must not tear the value
    rd_high(pos_exp);
    do_step(1'b1, 10);
    rd_low(pos_exp - 16'h0001);
    host_u.bus(1'b1, 1'b1);
    rd_all(pos_exp);
    for (int i = 0; i < 300; i++) begin
      do_step(1'($urandom_range(1, 0)), 4 + $urandom_range(8, 0));
      if (i % 50 == 49) begin
        repeat (12) @(negedge clk);
        rd_all(pos_exp);
      end
    end
    // leave the latch frozen by a lone high read, then reset mid-run
    while (host_u.idx_reg != 2'h0) do_step(1'b1, 10);
    rd_high(pos_exp);
    host_u.bus(1'b1, SEL_HIGH_BYTE);
    nrst = 1'b0;
    repeat (3) @(negedge clk);
    chk({d16, 7'h00, oe16}, 16'h0000);
    nrst = 1'b1;
    pos_exp = 16'h0000;
    do_step(1'b1, 10);
    rd_all(pos_exp);
    repeat (12) @(negedge clk);
    chk(16'(steps_seen), 16'(steps_exp));
    chk(16'(casc16_seen), 16'(casc16_exp));
    chk(16'(casc12_seen), 16'(casc12_exp));
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
